/* File: logic/channel_config_regs_b_c.sv */
// Purpose: Channel B and C configuration registers with global combining
// Assumes: AXI4-Lite register access; external inputs asynchronous to the core clock
// Notes:   Reads return stored bits, the status read returns live bits; outputs carry effective controls
//
// How it works
// - Bits 15 to 11 of each channel register read as zero and ignore writes.
// - Channel B pin shows I/O standard, comma detect, status 22:1 or 22:5 by selector 00/01/10/11.
// - Channel C pin uses the same codes but with status 22:2 and 22:6.
// - The effective pin selector is the OR of the channel and global fields, default 00.
// - Loss-of-signal detection runs only when channel and global enables are both set; channel default 1.
// - Effective config bit one is the OR of the external input, global bit 7 and channel bit 7.
// - Effective config bit zero is the OR of the external input, global bit 6 and channel bit 6.
// - While the matching external config input is high the config bit cannot be written.
// - Preemphasis bits 5 and 4 reset to 0 and OR with the global bits 5 and 4.
// - Loopback is the OR of the channel bit and core control bit 14; reset 0.
// - Pattern test enable is the OR of the channel bit, global bit 2 and the external pattern test input; reset 0.
// - While the external pattern test input is high the channel pattern bit cannot be written.
// - Comma detection needs the channel bit, the sync input and global bit 1 all set; channel default 1.
// - Power-down is the OR of the channel bit and core control bit 11; reset 0.
// - Channel C has its own register at index 19 with the same layout and behaviour.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps

module channel_config_regs_b_c
  import chan_cfg_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // AXI4-Lite slave
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // External pins, asynchronous
  input  wire logic        i_config_input_one,
  input  wire logic        i_config_input_zero,
  input  wire logic        i_pattern_test_enable_input,
  input  wire logic        i_sync_enable_input,
  input  wire logic        i_io_std_hstl,
  // Datapath status, same clock
  input  wire chan_sts_t   i_sts_b,
  input  wire chan_sts_t   i_sts_c,
  // Effective controls and pins
  output chan_ctl_t        o_ctl_b,
  output chan_ctl_t        o_ctl_c,
  output logic             o_channel_b_multi_pin,
  output logic             o_channel_c_multi_pin
);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_n;
  logic [2:0]  cfg1_s_q;
  logic [2:0]  cfg0_s_q;
  logic [2:0]  prbs_s_q;
  logic [2:0]  sync_s_q;
  logic [2:0]  iostd_s_q;
  ext_in_t     ext_q;
  logic        iostd_q;
  logic [15:0] global_q;
  logic [15:0] core_q;
  logic [15:0] chan_q [2];
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        wr_global;
  logic        wr_core;
  logic [15:0] sts_word;
  logic [15:0] lock_mask;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic [1:0]  wr_resp;
  logic        wr_hit;

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Three-flop input synchronisers; change accepted when stages two and three agree
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_s_q  <= 3'h0;
      cfg0_s_q  <= 3'h0;
      prbs_s_q  <= 3'h0;
      sync_s_q  <= 3'h0;
      iostd_s_q <= 3'h0;
    end else begin
      cfg1_s_q  <= {cfg1_s_q[1:0], i_config_input_one};
      cfg0_s_q  <= {cfg0_s_q[1:0], i_config_input_zero};
      prbs_s_q  <= {prbs_s_q[1:0], i_pattern_test_enable_input};
      sync_s_q  <= {sync_s_q[1:0], i_sync_enable_input};
      iostd_s_q <= {iostd_s_q[1:0], i_io_std_hstl};
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q   <= '0;
      iostd_q <= 1'b0;
    end else begin
      if (cfg1_s_q[1] == cfg1_s_q[2]) ext_q.config_input_one <= cfg1_s_q[2];
      if (cfg0_s_q[1] == cfg0_s_q[2]) ext_q.config_input_zero <= cfg0_s_q[2];
      if (prbs_s_q[1] == prbs_s_q[2]) ext_q.pattern_test_enable_input <= prbs_s_q[2];
      if (sync_s_q[1] == sync_s_q[2]) ext_q.sync_enable_input <= sync_s_q[2];
      if (iostd_s_q[1] == iostd_s_q[2]) iostd_q <= iostd_s_q[2];
    end
  end

  // Write channel capture; address and data taken in either order
  assign o_awready = !aw_held_q && !o_bvalid;
  assign o_wready  = !w_held_q && !o_bvalid;
  assign wr_fire   = aw_held_q && w_held_q && !o_bvalid;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= i_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= i_wdata;
      wstrb_q  <= i_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Merge byte lanes over a stored value; lanes 3 and 2 lie outside the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge = v;
  endfunction

  // Bits locked while the matching external input is high
  always_comb begin
    lock_mask = 16'h0000;
    lock_mask[CFG1_POS] = ext_q.config_input_one;
    lock_mask[CFG0_POS] = ext_q.config_input_zero;
    lock_mask[PRBS_POS] = ext_q.pattern_test_enable_input;
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (awaddr_q[11:2])
      CHAN_B_ADDR[11:2], CHAN_C_ADDR[11:2], GLOBAL_ADDR[11:2], CORE_CTL_ADDR[11:2]: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  assign wr_resp = wr_hit ? 2'b00 : 2'b10;

  // Per-register write strobes
  assign wr_global = wr_fire && (awaddr_q[11:2] == GLOBAL_ADDR[11:2]);
  assign wr_core   = wr_fire && (awaddr_q[11:2] == CORE_CTL_ADDR[11:2]);

  // Write response handshake; stands until taken
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bvalid <= 1'b0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Write response code, held with the handshake
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bresp <= 2'b00;
    end else if (wr_fire) begin
      o_bresp <= wr_resp;
    end
  end

  // Global register; locked bits keep their stored value
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_q <= GLOBAL_RESET;
    end else if (wr_global) begin
      global_q <= (merge(global_q, wdata_q, wstrb_q) & GLOBAL_WR_MASK & ~lock_mask) | (global_q & lock_mask);
    end
  end

  // Core control register: loopback and power-down only
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= CORE_RESET;
    end else if (wr_core) begin
      core_q <= merge(core_q, wdata_q, wstrb_q) & CORE_WR_MASK;
    end
  end

  // Channel B and C registers and effective controls
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [11:0] my_addr;
    logic [15:0] r;
    logic        mf_bit;
    chan_ctl_t   ctl;
    chan_sts_t   sts;
    logic        los_bit;
    logic        pass_bit;
    logic        wr_mine;
    assign my_addr = (ch == 0) ? CHAN_B_ADDR : CHAN_C_ADDR;
    assign r = chan_q[ch];
    assign wr_mine = wr_fire && (awaddr_q[11:2] == my_addr[11:2]);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
        chan_q[ch] <= CHAN_RESET;
      end else if (wr_mine) begin
        chan_q[ch] <= (merge(r, wdata_q, wstrb_q) & CHAN_WR_MASK & ~lock_mask) | (r & lock_mask);
      end
    end

    always_comb begin
      ctl.mf_sel     = r[MF_LO_POS +: 2] | global_q[MF_LO_POS +: 2];
      ctl.los_en     = r[LOS_POS] & global_q[LOS_POS];
      ctl.cfg1       = ext_q.config_input_one | global_q[CFG1_POS] | r[CFG1_POS];
      ctl.cfg0       = ext_q.config_input_zero | global_q[CFG0_POS] | r[CFG0_POS];
      ctl.emph_hi    = r[EMPH_HI_POS] | global_q[EMPH_HI_POS];
      ctl.emph_lo    = r[EMPH_LO_POS] | global_q[EMPH_LO_POS];
      ctl.loopback   = r[LOOP_POS] | core_q[CORE_LOOP_POS];
      ctl.prbs_en    = r[PRBS_POS] | global_q[PRBS_POS] | ext_q.pattern_test_enable_input;
      ctl.comma_en   = r[COMMA_POS] & ext_q.sync_enable_input & global_q[COMMA_POS];
      ctl.power_down = r[PDN_POS] | core_q[CORE_PDN_POS];
    end

    assign sts      = (ch == 0) ? i_sts_b : i_sts_c;
    assign los_bit  = (ch == 0) ? i_sts_b.los : i_sts_c.los;
    assign pass_bit = (ch == 0) ? i_sts_b.prbs_pass : i_sts_c.prbs_pass;

    always_comb begin
      case (mf_sel_t'(ctl.mf_sel))
        MF_IO_STD: mf_bit = iostd_q;
        MF_COMMA:  mf_bit = sts.comma_det;
        MF_LOS:    mf_bit = los_bit;
        MF_PASS:   mf_bit = pass_bit;
        default:   mf_bit = 1'b0;
      endcase
    end

    // Each channel drives only its own outputs
    if (ch == 0) begin : g_out_b
      always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_ctl_b               <= '0;
          o_channel_b_multi_pin <= 1'b0;
        end else begin
          o_ctl_b               <= ctl;
          o_channel_b_multi_pin <= mf_bit;
        end
      end
    end else begin : g_out_c
      always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_ctl_c               <= '0;
          o_channel_c_multi_pin <= 1'b0;
        end else begin
          o_ctl_c               <= ctl;
          o_channel_c_multi_pin <= mf_bit;
        end
      end
    end
  end

  // Read path returns stored bits, and live status bits at the status address
  assign o_arready = !o_rvalid;

  // Live status bits offered on the status read
  assign sts_word = {9'h000, i_sts_c.prbs_pass, i_sts_b.prbs_pass, 2'b00, i_sts_c.los, i_sts_b.los, 1'b0};

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    case (i_araddr[11:2])
      CHAN_B_ADDR[11:2]:   rd_val = chan_q[0] & CHAN_WR_MASK;
      CHAN_C_ADDR[11:2]:   rd_val = chan_q[1] & CHAN_WR_MASK;
      GLOBAL_ADDR[11:2]:   rd_val = global_q;
      CORE_CTL_ADDR[11:2]: rd_val = core_q;
      STATUS_ADDR[11:2]:   rd_val = sts_word;
      default:             rd_hit = 1'b0;
    endcase
  end

  // Read handshake; stands until taken
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rvalid <= 1'b0;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Read data captured with the address and held until taken
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'b00;
    end else if (i_arvalid && o_arready) begin
      o_rdata <= {16'h0000, rd_val};
      o_rresp <= rd_hit ? 2'b00 : 2'b10;
    end
  end

endmodule

/* File: common/chan_cfg_pkg.sv */
// Purpose: Shared constants and types for the channel B/C configuration registers
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes:   Register indices are kept; byte address is four times the index
package chan_cfg_pkg;

  // Register indices and byte addresses
  localparam logic [7:0]  CHAN_B_IDX      = 8'h12;
  localparam logic [7:0]  CHAN_C_IDX      = 8'h13;
  localparam logic [7:0]  GLOBAL_IDX      = 8'h10;
  localparam logic [7:0]  CORE_CTL_IDX    = 8'h00;
  localparam logic [7:0]  STATUS_IDX      = 8'h16;
  localparam logic [11:0] CHAN_B_ADDR     = 12'h048;
  localparam logic [11:0] CHAN_C_ADDR     = 12'h04c;
  localparam logic [11:0] GLOBAL_ADDR     = 12'h040;
  localparam logic [11:0] CORE_CTL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR     = 12'h058;

  // Field positions in a channel or global register
  localparam int MF_LO_POS    = 9;
  localparam int LOS_POS      = 8;
  localparam int CFG1_POS     = 7;
  localparam int CFG0_POS     = 6;
  localparam int EMPH_HI_POS  = 5;
  localparam int EMPH_LO_POS  = 4;
  localparam int LOOP_POS     = 3;
  localparam int PRBS_POS     = 2;
  localparam int COMMA_POS    = 1;
  localparam int PDN_POS      = 0;
  // Core control register fields
  localparam int CORE_LOOP_POS = 14;
  localparam int CORE_PDN_POS  = 11;
  // Status bits feeding the pins
  localparam int STS_LOS_B_POS  = 1;
  localparam int STS_LOS_C_POS  = 2;
  localparam int STS_PASS_B_POS = 5;
  localparam int STS_PASS_C_POS = 6;

  // Values after reset and writable-bit masks
  localparam logic [15:0] CHAN_RESET     = 16'h0102;
  localparam logic [15:0] GLOBAL_RESET   = 16'h0102;
  localparam logic [15:0] CORE_RESET     = 16'h0000;
  localparam logic [15:0] CHAN_WR_MASK   = 16'h07ff;
  localparam logic [15:0] GLOBAL_WR_MASK = 16'h07f6;
  localparam logic [15:0] CORE_WR_MASK   = 16'h4800;

  // Multifunction pin selector codes
  typedef enum logic [1:0] {
    MF_IO_STD = 2'b00,
    MF_COMMA  = 2'b01,
    MF_LOS    = 2'b10,
    MF_PASS   = 2'b11
  } mf_sel_t;

  // Effective per-channel controls
  typedef struct packed {
    logic [1:0] mf_sel;
    logic       los_en;
    logic       cfg1;
    logic       cfg0;
    logic       emph_hi;
    logic       emph_lo;
    logic       loopback;
    logic       prbs_en;
    logic       comma_en;
    logic       power_down;
  } chan_ctl_t;

  // Per-channel pin-facing status
  typedef struct packed {
    logic comma_det;
    logic los;
    logic prbs_pass;
  } chan_sts_t;

  // Synchronised external inputs
  typedef struct packed {
    logic config_input_one;
    logic config_input_zero;
    logic pattern_test_enable_input;
    logic sync_enable_input;
  } ext_in_t;

endpackage

/* File: tb/chan_cfg_properties.sv */
// Purpose: Port-level checks for the channel B/C configuration registers
// Assumes: One clock, active-low reset
// Notes:   Bound to the top module
`timescale 1ns/1ps

module chan_cfg_properties
  import chan_cfg_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        i_rready,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_bready,
  input wire chan_ctl_t   o_ctl_b,
  input wire chan_ctl_t   o_ctl_c,
  input wire chan_sts_t   i_sts_b,
  input wire chan_sts_t   i_sts_c,
  input wire logic        o_channel_b_multi_pin,
  input wire logic        o_channel_c_multi_pin,
  input wire logic        i_config_input_one,
  input wire logic        i_sync_enable_input
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_rd_upper_zero: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_pin_b_los: assert property ((o_ctl_b.mf_sel == MF_LOS && $stable(i_sts_b.los))[*3]
    |-> o_channel_b_multi_pin == i_sts_b.los) else $error("pin b los source wrong");
  a_pin_b_pass: assert property ((o_ctl_b.mf_sel == MF_PASS && $stable(i_sts_b.prbs_pass))[*3]
    |-> o_channel_b_multi_pin == i_sts_b.prbs_pass) else $error("pin b pass source wrong");
  a_pin_b_comma: assert property ((o_ctl_b.mf_sel == MF_COMMA && $stable(i_sts_b.comma_det))[*3]
    |-> o_channel_b_multi_pin == i_sts_b.comma_det) else $error("pin b comma source wrong");
  a_pin_c_los: assert property ((o_ctl_c.mf_sel == MF_LOS && $stable(i_sts_c.los))[*3]
    |-> o_channel_c_multi_pin == i_sts_c.los) else $error("pin c los source wrong");
  a_pin_c_pass: assert property ((o_ctl_c.mf_sel == MF_PASS && $stable(i_sts_c.prbs_pass))[*3]
    |-> o_channel_c_multi_pin == i_sts_c.prbs_pass) else $error("pin c pass source wrong");
  a_cfg_one_forced: assert property (i_config_input_one[*8] |-> o_ctl_b.cfg1 && o_ctl_c.cfg1)
    else $error("config input one not applied");
  a_comma_needs_sync: assert property ((!i_sync_enable_input)[*8] |-> !o_ctl_b.comma_en && !o_ctl_c.comma_en)
    else $error("comma detect on without sync input");
endmodule

bind channel_config_regs_b_c chan_cfg_properties chan_cfg_properties_inst (
  .i_core_clk, .i_nrst, .o_rvalid, .o_rdata, .i_rready, .o_bvalid, .o_bresp, .i_bready,
  .o_ctl_b, .o_ctl_c, .i_sts_b, .i_sts_c, .o_channel_b_multi_pin, .o_channel_c_multi_pin,
  .i_config_input_one, .i_sync_enable_input
);

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the channel B/C configuration registers
// Assumes: AXI4-Lite master driven at rising edges
// Notes:   Shadow registers give the expected register reads and controls
`timescale 1ns/1ps

module tb_top;
  import chan_cfg_pkg::*;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        p1, p0, pat, syn, hstl, awready, wready, bvalid, arready, rvalid, pin_b, pin_c;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  chan_sts_t   sb, sc;
  chan_ctl_t   cb, cc;
  logic [33:0] q[$];
  logic [33:0] exp_v, got_v;
  logic [15:0] sh[4];
  logic [11:0] ad[4] = '{CHAN_B_ADDR, CHAN_C_ADDR, GLOBAL_ADDR, CORE_CTL_ADDR};
  logic [15:0] wm[4] = '{CHAN_WR_MASK, CHAN_WR_MASK, GLOBAL_WR_MASK, CORE_WR_MASK};
  int          errors, comparisons;

  channel_config_regs_b_c channel_config_regs_b_c_inst (
    .i_core_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_config_input_one(p1), .i_config_input_zero(p0), .i_pattern_test_enable_input(pat),
    .i_sync_enable_input(syn), .i_io_std_hstl(hstl), .i_sts_b(sb), .i_sts_c(sc),
    .o_ctl_b(cb), .o_ctl_c(cc), .o_channel_b_multi_pin(pin_b), .o_channel_c_multi_pin(pin_c)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic fail(string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic chan_ctl_t eff(logic [15:0] c);
    eff = {c[10:9] | sh[2][10:9], c[8] & sh[2][8], c[7:4] | sh[2][7:4] | {p1, p0, 2'b00},
           c[3] | sh[3][14], c[2] | sh[2][2] | pat, c[1] & sh[2][1] & syn, c[0] | sh[3][11]};
  endfunction

  function automatic logic pin(chan_ctl_t e, chan_sts_t s);
    case (e.mf_sel)
      MF_IO_STD: pin = hstl;
      MF_COMMA:  pin = s.comma_det;
      MF_LOS:    pin = s.los;
      default:   pin = s.prbs_pass;
    endcase
  endfunction

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    q.push_back({r, 32'h0});
    @(posedge clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, logic [15:0] e, logic [1:0] r);
    q.push_back({r, 16'h0, e});
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic wreg(int k, logic [31:0] d, logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & ~{8'h0, p1, p0, 3'b000, pat, 2'b00} & wm[k];
    sh[k] = (sh[k] & ~m) | (d[15:0] & m);
    wr(ad[k], d, s, 2'b00);
    rd(ad[k], sh[k], 2'b00);
  endtask

  task automatic settle();
    repeat (10) @(posedge clk);
    chk({5'h0, cb}, {5'h0, eff(sh[0])}, "ctl b");
    chk({5'h0, cc}, {5'h0, eff(sh[1])}, "ctl c");
    chk({15'h0, pin_b}, {15'h0, pin(eff(sh[0]), sb)}, "pin b");
    chk({15'h0, pin_c}, {15'h0, pin(eff(sh[1]), sc)}, "pin c");
  endtask

  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      comparisons++;
      if (q.size() == 0) fail("unexpected response");
      else begin
        exp_v = q.pop_front();
        got_v = rvalid ? {rresp, rdata} : {bresp, 32'h0};
        if (got_v !== exp_v) fail("bus response");
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail("timeout");
    close_out();
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {p1, p0, pat, syn, hstl, sb, sc} = '0;
    errors = 0;
    comparisons = 0;
    sh = '{CHAN_RESET, CHAN_RESET, GLOBAL_RESET, CORE_RESET};
    void'($urandom(88128));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CHAN_B_ADDR, CHAN_RESET, 2'b00);
    rd(CHAN_C_ADDR, CHAN_RESET, 2'b00);
    wr(12'h7f0, 32'hffffffff, 4'hf, 2'b10);
    rd(12'h7f0, 16'h0000, 2'b10);
    wreg(0, 32'hffffffff, 4'hf);
    wreg(1, 32'h0000ff00, 4'h2);
    settle();
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      {p1, p0, pat, syn, hstl, sb, sc} <= 11'($urandom);
      repeat (10) @(posedge clk);
      wreg($urandom_range(0, 3), $urandom, 4'($urandom));
      settle();
    end
    wreg(2, 32'h0, 4'hf);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      {hstl, sb, sc} <= 7'($urandom);
      wreg(0, 32'(m) << 9, 4'hf);
      wreg(1, 32'(3 - m) << 9, 4'hf);
      settle();
    end
    close_out();
  end
endmodule
